// ---- include/can_rx_irq_pkg.sv ----
// Purpose: shared constants and types for the receive interrupt enable block
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes: bit positions are shared by the flag and enable registers
package can_rx_irq_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] FLAGS_OFFSET = 8'h00;
    localparam logic [7:0] ENABLES_OFFSET = 8'h04;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------------
    // field positions, common to flags and enables
    // ------------------------------------------------------------------
    localparam int WAKE_BIT = 7;
    localparam int STATE_CHANGE_BIT = 6;
    localparam int RX_STATE_LSB = 4;
    localparam int TX_STATE_LSB = 2;
    localparam int OVERRUN_BIT = 1;
    localparam int RX_FULL_BIT = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ENABLES_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // bits of the enable register that initialization mode holds at reset
    localparam logic [7:0] INIT_HELD_MASK = 8'hC3;
    // flag bits that a written one clears
    localparam logic [7:0] FLAG_W1C_MASK = 8'hC3;

    // ------------------------------------------------------------------
    // error counter thresholds
    // ------------------------------------------------------------------
    localparam int WARN_LIMIT = 96;
    localparam int ERR_LIMIT = 127;
    localparam int BUS_OFF_LIMIT = 255;

    // ------------------------------------------------------------------
    // encoded bus state and sensitivity codes
    // ------------------------------------------------------------------
    typedef logic [1:0] err_state_t;
    localparam err_state_t STATE_OK = 2'h0;
    localparam err_state_t STATE_WARNING = 2'h1;
    localparam err_state_t STATE_ERROR = 2'h2;
    localparam err_state_t STATE_BUS_OFF = 2'h3;

    localparam logic [1:0] SENS_NONE = 2'h0;
    localparam logic [1:0] SENS_BUS_OFF = 2'h1;
    localparam logic [1:0] SENS_ERROR = 2'h2;
    localparam logic [1:0] SENS_ALL = 2'h3;

    // ------------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// ---- include/reg_access_if.sv ----
// Purpose: carries decoded register accesses from the bus front end
// Assumes: one clock, strobes are one-cycle pulses
// Notes: rdata is sampled by the front end during a read's wait cycle
`timescale 1ns/10ps
interface reg_access_if;
    import can_rx_irq_pkg::*;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0] wdata;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0] rdata;

    modport front (output wr_en, output wr_addr, output wdata, output rd_addr, input rdata);
    modport regs (input wr_en, input wr_addr, input wdata, input rd_addr, output rdata);
endinterface

// ---- hw/state_change_filter.sv ----
// Purpose: decides whether a bus state transition passes a sensitivity level
// Assumes: states use the ok/warning/error/bus-off encoding
// Notes: combinational, one instance per direction
`timescale 1ns/10ps
module state_change_filter
    import can_rx_irq_pkg::*;
(
    input wire logic [1:0] sensitivity,
    input wire err_state_t old_state,
    input wire err_state_t new_state,
    output logic hit
);
    wire changed = (old_state != new_state);
    wire bus_off_cross = (old_state == STATE_BUS_OFF) != (new_state == STATE_BUS_OFF);
    // upper bit set means error or bus-off
    wire error_cross = (old_state[1] != new_state[1]) | bus_off_cross;

    always_comb begin
        unique case (sensitivity)
            SENS_NONE: hit = 1'b0;
            SENS_BUS_OFF: hit = bus_off_cross;
            SENS_ERROR: hit = error_cross;
            SENS_ALL: hit = changed;
        endcase
    end
endmodule

// ---- hw/ahb_reg_front.sv ----
// Purpose: AHB-Lite slave front end for byte-wide registers
// Assumes: single word transfers, one slave on the bus
// Notes: writes complete with no wait; reads insert one wait cycle
`timescale 1ns/10ps
module ahb_reg_front
    import can_rx_irq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    reg_access_if.front acc
);
    logic wr_phase_r;
    logic rd_phase_r;
    logic rd_done_r;
    logic [ADDR_W-1:0] addr_r;
    logic [31:0] hrdata_r;

    wire take = hsel & hready & (htrans == HTRANS_NONSEQ);
    // only whole-word writes are taken; reads of any size are still served
    wire word_ok = (hsize == HSIZE_WORD);
    wire rd_wait = rd_phase_r & ~rd_done_r;

    // ------------------------------------------------------------------
    // address phase capture
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_phase_r <= 1'b0;
            rd_phase_r <= 1'b0;
            addr_r <= '0;
        end else if (hreadyout) begin
            wr_phase_r <= take & hwrite & word_ok;
            rd_phase_r <= take & ~hwrite;
            addr_r <= haddr[ADDR_W-1:0];
        end
    end

    // reading one cycle late sees a write committed just before
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_done_r <= 1'b0;
            hrdata_r <= '0;
        end else begin
            rd_done_r <= rd_wait;
            if (rd_wait) begin
                hrdata_r <= {24'h000000, acc.rdata};
            end
        end
    end

    assign acc.wr_en = wr_phase_r;
    assign acc.wr_addr = addr_r;
    assign acc.wdata = hwdata[7:0];
    assign acc.rd_addr = addr_r;
    assign hrdata = hrdata_r;
    assign hreadyout = ~rd_wait;
    assign hresp = 1'b0;
endmodule

// ---- hw/can_rx_interrupt_enable.sv ----
// Purpose: receive side interrupt enables, flags and request gating
// Assumes: counters, events and init handshake come from logic on hclk
// Notes: flag register lives here too; its masks are the enable bits
`timescale 1ns/10ps
module can_rx_interrupt_enable
    import can_rx_irq_pkg::*;
#(
    parameter int REC_W = 8,
    parameter int TEC_W = 9
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic init_request,
    input wire logic init_acknowledge,
    input wire logic [REC_W-1:0] rx_err_count,
    input wire logic [TEC_W-1:0] tx_err_count,
    input wire logic sleep_mode,
    input wire logic sleep_wake_en,
    input wire logic bus_activity,
    input wire logic overrun_event,
    input wire logic rx_queue_pending,
    output logic rx_shift,
    output logic wake_irq,
    output logic error_irq,
    output logic rx_irq,
    output logic irq
);
    // ------------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------------
    reg_access_if acc ();

    ahb_reg_front u_front (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .acc(acc)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] enables_r;
    logic [7:0] enables_nxt;
    logic wake_flag_r;
    logic state_change_flag_r;
    logic overrun_flag_r;
    logic rx_full_flag_r;
    err_state_t rx_error_state_r;
    err_state_t tx_error_state_r;

    // ------------------------------------------------------------------
    // mode and access decode
    // ------------------------------------------------------------------
    wire init_mode = init_request & init_acknowledge;
    wire init_idle = ~init_request & ~init_acknowledge;
    wire enables_sel = (acc.wr_addr == ENABLES_OFFSET);
    wire flags_sel = (acc.wr_addr == FLAGS_OFFSET);
    // an enable write during the handshake in either direction is dropped
    wire enables_wr = acc.wr_en & enables_sel & init_idle;
    wire flags_wr = acc.wr_en & flags_sel;
    wire [7:0] clear_bits = flags_wr ? (acc.wdata & FLAG_W1C_MASK) : 8'h00;

    wire wake_irq_en = enables_r[WAKE_BIT];
    wire state_change_irq_en = enables_r[STATE_CHANGE_BIT];
    wire [1:0] rx_state_sensitivity = enables_r[RX_STATE_LSB +: 2];
    wire [1:0] tx_state_sensitivity = enables_r[TX_STATE_LSB +: 2];
    wire overrun_irq_en = enables_r[OVERRUN_BIT];
    wire rx_full_irq_en = enables_r[RX_FULL_BIT];

    // ------------------------------------------------------------------
    // enable register
    // ------------------------------------------------------------------
    always_comb begin
        enables_nxt = enables_r;
        if (init_mode) begin
            // enable bits go to reset, sensitivity fields stay put
            enables_nxt = (enables_r & ~INIT_HELD_MASK) | (ENABLES_RESET & INIT_HELD_MASK);
        end else if (enables_wr) begin
            enables_nxt = acc.wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enables_r <= ENABLES_RESET;
        end else begin
            enables_r <= enables_nxt;
        end
    end

    // ------------------------------------------------------------------
    // bus state from error counters
    // ------------------------------------------------------------------
    wire tx_bus_off = tx_err_count > TEC_W'(BUS_OFF_LIMIT);
    wire rx_over_err = rx_err_count > REC_W'(ERR_LIMIT);
    wire rx_over_warn = rx_err_count > REC_W'(WARN_LIMIT);
    wire tx_over_err = tx_err_count > TEC_W'(ERR_LIMIT);
    wire tx_over_warn = tx_err_count > TEC_W'(WARN_LIMIT);

    // bus-off overrides the receiver's own count
    wire err_state_t rx_state_now = tx_bus_off ? STATE_BUS_OFF :
        rx_over_err ? STATE_ERROR :
        rx_over_warn ? STATE_WARNING : STATE_OK;
    wire err_state_t tx_state_now = tx_bus_off ? STATE_BUS_OFF :
        tx_over_err ? STATE_ERROR :
        tx_over_warn ? STATE_WARNING : STATE_OK;

    // ------------------------------------------------------------------
    // transition classification
    // ------------------------------------------------------------------
    logic rx_hit;
    logic tx_hit;

    state_change_filter u_rx_filter (
        .sensitivity(rx_state_sensitivity),
        .old_state(rx_error_state_r),
        .new_state(rx_state_now),
        .hit(rx_hit)
    );

    state_change_filter u_tx_filter (
        .sensitivity(tx_state_sensitivity),
        .old_state(tx_error_state_r),
        .new_state(tx_state_now),
        .hit(tx_hit)
    );

    // a pending flag freezes the state fields
    wire state_update = ~state_change_flag_r;
    wire state_change_set = state_update & (rx_hit | tx_hit);

    // ------------------------------------------------------------------
    // events
    // ------------------------------------------------------------------
    wire wake_set = sleep_mode & sleep_wake_en & bus_activity;
    // next queue entry may only move in while the foreground is free
    assign rx_shift = rx_queue_pending & ~rx_full_flag_r;

    // ------------------------------------------------------------------
    // flags: a set in the clearing cycle wins
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_flag_r <= FLAGS_RESET[WAKE_BIT];
            state_change_flag_r <= FLAGS_RESET[STATE_CHANGE_BIT];
            overrun_flag_r <= FLAGS_RESET[OVERRUN_BIT];
            rx_full_flag_r <= FLAGS_RESET[RX_FULL_BIT];
        end else begin
            wake_flag_r <= wake_set | (wake_flag_r & ~clear_bits[WAKE_BIT]);
            state_change_flag_r <= state_change_set |
                (state_change_flag_r & ~clear_bits[STATE_CHANGE_BIT]);
            overrun_flag_r <= overrun_event | (overrun_flag_r & ~clear_bits[OVERRUN_BIT]);
            rx_full_flag_r <= rx_shift | (rx_full_flag_r & ~clear_bits[RX_FULL_BIT]);
        end
    end

    // ------------------------------------------------------------------
    // state fields, untouched by initialization mode
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_error_state_r <= STATE_OK;
            tx_error_state_r <= STATE_OK;
        end else if (state_update) begin
            rx_error_state_r <= rx_state_now;
            tx_error_state_r <= tx_state_now;
        end
    end

    // ------------------------------------------------------------------
    // interrupt requests
    // ------------------------------------------------------------------
    assign wake_irq = wake_flag_r & wake_irq_en;
    assign error_irq = (state_change_flag_r & state_change_irq_en) |
        (overrun_flag_r & overrun_irq_en);
    assign rx_irq = rx_full_flag_r & rx_full_irq_en;
    assign irq = wake_irq | error_irq | rx_irq;

    // ------------------------------------------------------------------
    // read back
    // ------------------------------------------------------------------
    wire [7:0] flags_view = {wake_flag_r, state_change_flag_r, rx_error_state_r,
        tx_error_state_r, overrun_flag_r, rx_full_flag_r};
    wire rd_flags = (acc.rd_addr == FLAGS_OFFSET);
    wire rd_enables = (acc.rd_addr == ENABLES_OFFSET);
    // unmapped addresses read as zero
    assign acc.rdata = rd_flags ? flags_view : (rd_enables ? enables_r : 8'h00);
endmodule

// ---- bench/can_rx_irq_checker.sv ----
// Purpose: port level assertions for the receive interrupt block
// Assumes: one hclk domain, hresetn asynchronous and active low
// Notes: enables are not visible here, so request edges are tied to causes
`timescale 1ns/10ps
module can_rx_irq_checker
    import can_rx_irq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic init_request,
    input wire logic init_acknowledge,
    input wire logic sleep_mode,
    input wire logic sleep_wake_en,
    input wire logic bus_activity,
    input wire logic rx_queue_pending,
    input wire logic rx_shift,
    input wire logic wake_irq,
    input wire logic error_irq,
    input wire logic rx_irq,
    input wire logic irq
);
    // ----------
    // write data phase tracking
    // ----------
    logic wr_dp_r, wr_dp_nxt, rd_take, init_on, wake_cause;
    assign wr_dp_nxt = hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;
    assign rd_take = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;
    assign init_on = init_request && init_acknowledge;
    assign wake_cause = sleep_mode && sleep_wake_en && bus_activity;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dp_r <= 1'b0;
        end else begin
            wr_dp_r <= wr_dp_nxt;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_irq_or_gate: assert property (irq == (wake_irq | error_irq | rx_irq))
        else $error("irq is not the or of the requests");
    a_shift_then_block: assert property (rx_shift |-> rx_queue_pending ##1 !rx_shift)
        else $error("receive shift not blocked by full flag");
    a_wake_rise_cause: assert property ($rose(wake_irq) |->
        $past(wake_cause) || $past(wr_dp_r)) else $error("wake request without cause");
    a_rx_rise_cause: assert property ($rose(rx_irq) |->
        $past(rx_shift) || $past(wr_dp_r)) else $error("receive request without cause");
    a_irq_fall_cause: assert property ($fell(irq) |->
        $past(wr_dp_r) || $past(init_on)) else $error("irq dropped without cause");
    a_init_quiets_all: assert property (init_on |=> !wake_irq && !error_irq && !rx_irq)
        else $error("request active during initialization");
    a_read_one_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait cycle wrong");
    a_write_no_wait: assert property (wr_dp_r |-> hreadyout)
        else $error("write data phase stalled");
    c_wake: cover property ($rose(wake_irq));
    c_error: cover property ($rose(error_irq));
    c_rx: cover property (rx_shift ##1 rx_irq);
    c_init: cover property (init_on);
endmodule

bind can_rx_interrupt_enable can_rx_irq_checker can_rx_irq_checker_inst (.*);

// ---- bench/ahb_host_model.sv ----
// Purpose: host side register bus master for the receive interrupt block
// Assumes: one slave whose hreadyout is hready, single word transfers
// Notes: waits on hready without limit; the bench watchdog cuts hangs
`timescale 1ns/10ps
module ahb_host_model
    import can_rx_irq_pkg::*;
(
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h00000000;
    end
    // ----------
    // single transfer, reads allowed at any time
    // ----------
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, addr};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
endmodule

// ---- bench/can_rx_interrupt_enable_tb_top.sv ----
// Purpose: self-checking bench for the receive interrupt enable block
// Assumes: host model owns the register bus, bench drives the event inputs
// Notes: inputs change at rising edges, request outputs are sampled at falling edges, read data at rising edges
`timescale 1ns/10ps
module can_rx_interrupt_enable_tb_top
    import can_rx_irq_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic init_request = 1'b0;
    logic init_acknowledge = 1'b0;
    logic [7:0] rx_err_count = 8'h00;
    logic [8:0] tx_err_count = 9'h000;
    logic sleep_mode = 1'b0;
    logic sleep_wake_en = 1'b0;
    logic bus_activity = 1'b0;
    logic overrun_event = 1'b0;
    logic rx_queue_pending = 1'b0;
    logic hsel, hwrite, hready, hresp, rx_shift, wake_irq, error_irq, rx_irq, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int miscompares = 0;
    int total_checks = 0;
    localparam int REC_SEQ [4] = '{100, 200, 200, 0};
    localparam int TEC_SEQ [4] = '{0, 0, 300, 0};
    localparam int TX_SEQ [4] = '{100, 200, 300, 0};
    localparam int MIN_CODE [4] = '{3, 2, 1, 1};
    always #25 hclk = ~hclk;
    ahb_host_model ahb_host_model_inst (.*);
    can_rx_interrupt_enable can_rx_interrupt_enable_inst (.hreadyout(hready), .*);
    // ----------
    // shared helpers
    // ----------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] unused;
        ahb_host_model_inst.xfer(1'b1, a, {24'h000000, d}, unused);
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] d;
        ahb_host_model_inst.xfer(1'b0, a, 32'h00000000, d);
        check(d, {24'h000000, exp});
        check({31'h00000000, hresp}, 32'h00000000);
    endtask
    // order of exp: wake, error, receive, combined
    task automatic irqs(input logic [3:0] exp);
        @(negedge hclk);
        check({28'h0000000, wake_irq, error_irq, rx_irq, irq}, {28'h0000000, exp});
    endtask
    function automatic logic [1:0] lvl(input int n);
        return (n > 255) ? 2'h3 : (n > 127) ? 2'h2 : (n > 96) ? 2'h1 : 2'h0;
    endfunction
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_init();
        rd_check(ENABLES_OFFSET, 8'h00);
        rd_check(8'h08, 8'h00);
        wr(ENABLES_OFFSET, 8'hFF);
        init_request <= 1'b1;
        wr(ENABLES_OFFSET, 8'h00);
        rd_check(ENABLES_OFFSET, 8'hFF);
        init_acknowledge <= 1'b1;
        wr(ENABLES_OFFSET, 8'hC3);
        rd_check(ENABLES_OFFSET, 8'h3C);
        init_request <= 1'b0;
        wr(ENABLES_OFFSET, 8'h81);
        rd_check(ENABLES_OFFSET, 8'h3C);
        init_acknowledge <= 1'b0;
        wr(ENABLES_OFFSET, 8'h00);
        rd_check(ENABLES_OFFSET, 8'h00);
    endtask
    task automatic t_wake();
        sleep_mode <= 1'b1;
        sleep_wake_en <= 1'b1;
        bus_activity <= 1'b1;
        @(posedge hclk);
        bus_activity <= 1'b0;
        irqs(4'h0);
        rd_check(FLAGS_OFFSET, 8'h80);
        wr(ENABLES_OFFSET, 8'h80);
        irqs(4'h9);
        wr(FLAGS_OFFSET, 8'h80);
        irqs(4'h0);
    endtask
    task automatic t_rx();
        @(posedge hclk);
        rx_queue_pending <= 1'b1;
        @(negedge hclk);
        check({31'h00000000, rx_shift}, 32'h00000001);
        irqs(4'h0);
        check({31'h00000000, rx_shift}, 32'h00000000);
        wr(ENABLES_OFFSET, 8'h01);
        irqs(4'h3);
        @(posedge hclk);
        rx_queue_pending <= 1'b0;
        wr(FLAGS_OFFSET, 8'h01);
        irqs(4'h0);
    endtask
    task automatic t_overrun();
        wr(ENABLES_OFFSET, 8'h02);
        overrun_event <= 1'b1;
        @(posedge hclk);
        overrun_event <= 1'b0;
        irqs(4'h5);
        // entering init with a request pending must silence it
        @(posedge hclk);
        init_request <= 1'b1;
        init_acknowledge <= 1'b1;
        @(posedge hclk);
        irqs(4'h0);
        @(posedge hclk);
        init_request <= 1'b0;
        init_acknowledge <= 1'b0;
        rd_check(ENABLES_OFFSET, 8'h00);
        wr(ENABLES_OFFSET, 8'h00);
        irqs(4'h0);
        rd_check(FLAGS_OFFSET, 8'h02);
        wr(FLAGS_OFFSET, 8'h02);
    endtask
    task automatic t_sens();
        int rec;
        int tec;
        logic hit;
        for (int dir = 0; dir < 2; dir++) begin
            for (int code = 0; code < 4; code++) begin
                wr(ENABLES_OFFSET, dir ? {4'h4, code[1:0], 2'h0} : {2'h1, code[1:0], 4'h0});
                for (int s = 0; s < 4; s++) begin
                    rec = dir ? 0 : REC_SEQ[s];
                    tec = dir ? TX_SEQ[s] : TEC_SEQ[s];
                    hit = (code >= MIN_CODE[s]);
                    rx_err_count <= rec[7:0];
                    tx_err_count <= tec[8:0];
                    @(posedge hclk);
                    irqs({1'b0, hit, 1'b0, hit});
                    rd_check(FLAGS_OFFSET, {1'b0, hit, (tec > 255) ? 2'h3 : lvl(rec),
                        lvl(tec), 2'h0});
                    wr(FLAGS_OFFSET, 8'h40);
                end
            end
        end
    endtask
    task automatic t_freeze();
        wr(ENABLES_OFFSET, 8'h30);
        rx_err_count <= 8'h64;
        repeat (2) @(posedge hclk);
        rx_err_count <= 8'hC8;
        rd_check(FLAGS_OFFSET, 8'h50);
        irqs(4'h0);
        wr(FLAGS_OFFSET, 8'h40);
        rd_check(FLAGS_OFFSET, 8'h60);
        rx_err_count <= 8'h00;
        wr(FLAGS_OFFSET, 8'h40);
        wr(FLAGS_OFFSET, 8'h40);
        rd_check(FLAGS_OFFSET, 8'h00);
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_init();
        t_wake();
        t_rx();
        t_overrun();
        t_sens();
        t_freeze();
        print_verdict();
    end
    // the whole run takes about 400 cycles
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule
